// ===== common/drs_pkg.sv
package drs_pkg;

  // Register byte offsets.
  localparam logic [7:0] DRS_ASSIGN1_OFS = 8'h00;
  localparam logic [7:0] DRS_ASSIGN5_OFS = 8'h10;
  localparam logic [7:0] DRS_POL_OFS = 8'h14;
  localparam logic [7:0] DRS_CTRL_OFS = 8'h18;
  localparam logic [7:0] DRS_STATUS_OFS = 8'h1c;
  localparam logic [7:0] DRS_IRQ_STAT_OFS = 8'h20;
  localparam logic [7:0] DRS_IRQ_MASK_OFS = 8'h24;

  // Field positions.
  localparam int DRS_CTRL_EDGE_BIT = 0;
  localparam int DRS_ST_TRIP_BIT = 0;
  localparam int DRS_ST_RSTACT_BIT = 1;
  localparam int DRS_ST_ALARM_BIT = 2;
  localparam int DRS_ST_REMERR_BIT = 3;
  localparam int DRS_ST_MOTOR_BIT = 4;
  localparam int DRS_ST_SEQ_BIT = 5;
  localparam int DRS_IRQ_DONE_BIT = 0;
  localparam int DRS_IRQ_TRIP_BIT = 1;
  localparam int DRS_IRQ_REMERR_BIT = 2;
  localparam int DRS_IRQ_NCREF_BIT = 3;

  // Reset values.
  localparam logic [7:0] DRS_ASSIGN_RST = 8'h00;
  localparam logic [4:0] DRS_POL_RST = 5'h00;
  localparam logic DRS_EDGE_RST = 1'b0;
  localparam logic [3:0] DRS_IRQ_MASK_RST = 4'h0;

  // Option code that selects the reset function on a terminal.
  localparam logic [7:0] DRS_FUNC_RESET = 8'd18;
  localparam int DRS_NUM_TERMS = 5;

  // Timing, in their own units and then in clock cycles or ms ticks.
  localparam int DRS_CLK_PERIOD_NS = 50;
  localparam int DRS_TICK_NS = 1000000;
  localparam int DRS_TICK_CYCLES = DRS_TICK_NS / DRS_CLK_PERIOD_NS;
  localparam int DRS_MIN_PULSE_MS = 12;
  localparam int DRS_ALARM_CLEAR_MS = 30;
  localparam int DRS_PU_HOLD_S = 4;
  localparam int DRS_PU_HOLD_MS = DRS_PU_HOLD_S * 1000;
  localparam int DRS_SEQ_MS = 2;

  typedef enum logic [2:0] {
    DRS_PU = 3'b001,
    DRS_IDLE = 3'b010,
    DRS_SEQ = 3'b100
  } drs_state_t;

endpackage

// ===== common/drs_in_if.sv
`timescale 1ns/10ps
interface drs_in_if;
  logic [4:0] level;
  logic tick;
  modport src (output level, output tick);
  modport dst (input level, input tick);
endinterface

// ===== logic/drs_in_sync.sv
`timescale 1ns/10ps
module drs_in_sync
  import drs_pkg::*;
#(
  parameter int TICK_CYCLES = DRS_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [4:0] term_pin,
  drs_in_if.src sync_out
);

  logic [4:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic [31:0] div_q, div_d;
  logic tick_q, tick_d;

  ////////////////////////////////////////////////////////////////////////////
  // A level change counts only once stages two and three agree.
  always_comb begin
    lvl_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
    div_d = div_q + 32'd1;
    tick_d = 1'b0;
    if (div_q == 32'(TICK_CYCLES - 1)) begin
      div_d = 32'd0;
      tick_d = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_bit
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          lvl_q[gi] <= 1'b0;
        end else if (clk_en) begin
          s1_q[gi] <= term_pin[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          lvl_q[gi] <= lvl_d[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= 32'd0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign sync_out.level = lvl_q;
  assign sync_out.tick = tick_q;

endmodule

// ===== logic/drs_top.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
module drs_top
  import drs_pkg::*;
#(
  parameter int TICK_CYCLES = DRS_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] input_terminal,
  input wire logic fault_event,
  input wire logic run_cmd,
  input wire logic operator_key,
  output logic motor_enable,
  output logic alarm_out,
  output logic powerup_reset,
  output logic remote_link_error_message,
  output logic irq
);

  drs_in_if sync_if ();

  drs_in_sync #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .term_pin(input_terminal),
    .sync_out(sync_if.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  logic [7:0] assign_q [DRS_NUM_TERMS];
  logic [7:0] assign_d [DRS_NUM_TERMS];
  logic [4:0] pol_q, pol_d;
  logic reset_edge_select_q, reset_edge_select_d;
  logic [3:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic wr_en, rd_setup, addr_ok;
  logic [4:0] is_rst_term, nc_req;
  logic nc_refused;
  logic [3:0] ev;

  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= DRS_IRQ_MASK_OFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_q;

  genvar gi;
  generate
    for (gi = 0; gi < DRS_NUM_TERMS; gi++) begin : g_term
      // Only these five assignment slots can carry the reset function.
      assign is_rst_term[gi] = (assign_q[gi] == DRS_FUNC_RESET);
    end
  endgenerate

  logic [31:0] status_w;
  logic trip_q, trip_d;
  drs_state_t state_q, state_d;
  logic rem_err_q, rem_err_d;
  logic rst_level;

  always_comb begin
    status_w = 32'h0;
    status_w[DRS_ST_TRIP_BIT] = trip_q;
    status_w[DRS_ST_RSTACT_BIT] = rst_level;
    status_w[DRS_ST_ALARM_BIT] = trip_q;
    status_w[DRS_ST_REMERR_BIT] = rem_err_q;
    status_w[DRS_ST_MOTOR_BIT] = motor_enable;
    status_w[DRS_ST_SEQ_BIT] = (state_q != DRS_IDLE);
  end

  always_comb begin
    logic [7:0] tmp;
    tmp = 8'h00;
    assign_d = assign_q;
    pol_d = pol_q;
    reset_edge_select_d = reset_edge_select_q;
    irq_mask_d = irq_mask_q;
    prdata_d = prdata_q;
    nc_refused = 1'b0;
    if (wr_en && addr_ok) begin
      for (int i = 0; i < DRS_NUM_TERMS; i++) begin
        if (paddr == DRS_ASSIGN1_OFS + 8'(4 * i)) begin
          assign_d[i] = pwdata[7:0];
        end
      end
      if (paddr == DRS_POL_OFS) begin
        pol_d = pwdata[4:0];
      end
      if (paddr == DRS_CTRL_OFS) begin
        reset_edge_select_d = pwdata[DRS_CTRL_EDGE_BIT];
      end
      if (paddr == DRS_IRQ_MASK_OFS) begin
        irq_mask_d = pwdata[3:0];
      end
    end
    // A reset terminal is forced back to normally open.
    nc_req = pol_d & is_rst_term;
    if (|nc_req) begin
      pol_d = pol_d & ~nc_req;
      nc_refused = 1'b1;
    end
    if (rd_setup) begin
      prdata_d = 32'h0;
      for (int i = 0; i < DRS_NUM_TERMS; i++) begin
        if (paddr == DRS_ASSIGN1_OFS + 8'(4 * i)) begin
          tmp = assign_q[i];
          prdata_d = {24'h0, tmp};
        end
      end
      case (paddr)
        DRS_POL_OFS: prdata_d = {27'h0, pol_q};
        DRS_CTRL_OFS: prdata_d = {31'h0, reset_edge_select_q};
        DRS_STATUS_OFS: prdata_d = status_w;
        DRS_IRQ_STAT_OFS: prdata_d = {28'h0, irq_stat_q};
        DRS_IRQ_MASK_OFS: prdata_d = {28'h0, irq_mask_q};
        default: prdata_d = prdata_d;
      endcase
    end
  end

  // Events win over a write-one-to-clear in the same cycle.
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_en && paddr == DRS_IRQ_STAT_OFS) begin
      irq_stat_d = irq_stat_q & ~pwdata[3:0];
    end
    irq_stat_d = irq_stat_d | ev;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DRS_NUM_TERMS; i++) begin
        assign_q[i] <= DRS_ASSIGN_RST;
      end
      pol_q <= DRS_POL_RST;
      reset_edge_select_q <= DRS_EDGE_RST;
      irq_stat_q <= 4'h0;
      irq_mask_q <= DRS_IRQ_MASK_RST;
      prdata_q <= 32'h0;
    end else if (clk_en) begin
      assign_q <= assign_d;
      pol_q <= pol_d;
      reset_edge_select_q <= reset_edge_select_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset request detection and sequencing.
  logic [4:0] term_lvl;
  logic rst_prev_q, rst_prev_d;
  logic [7:0] on_ms_q, on_ms_d;
  logic fired_q, fired_d;
  logic [7:0] seq_ms_q, seq_ms_d;
  logic pu_hold_q, pu_hold_d;
  logic [12:0] pu_ms_q, pu_ms_d;
  logic req;
  logic tick;

  assign term_lvl = sync_if.level;
  assign tick = sync_if.tick;
  assign rst_level = |(term_lvl & is_rst_term);

  always_comb begin
    rst_prev_d = rst_level;
    on_ms_d = on_ms_q;
    fired_d = fired_q;
    req = 1'b0;
    if (rst_level) begin
      if (tick && on_ms_q != 8'hff) begin
        on_ms_d = on_ms_q + 8'd1;
      end
      // Leading mode fires once the pulse has proven itself long enough.
      if (!reset_edge_select_q && !fired_q && on_ms_q >= 8'(DRS_MIN_PULSE_MS)) begin
        req = 1'b1;
        fired_d = 1'b1;
      end
    end else begin
      on_ms_d = 8'h00;
      fired_d = 1'b0;
      if (rst_prev_q && reset_edge_select_q && on_ms_q >= 8'(DRS_MIN_PULSE_MS)) begin
        req = 1'b1;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    seq_ms_d = seq_ms_q;
    trip_d = trip_q;
    ev = 4'h0;
    ev[DRS_IRQ_NCREF_BIT] = nc_refused;
    case (state_q)
      DRS_PU: begin
        state_d = DRS_SEQ;
        seq_ms_d = 8'h00;
      end
      DRS_IDLE: begin
        if (req) begin
          state_d = DRS_SEQ;
          seq_ms_d = 8'h00;
        end
      end
      DRS_SEQ: begin
        if (tick) begin
          seq_ms_d = seq_ms_q + 8'd1;
        end
        if (seq_ms_q >= 8'(DRS_SEQ_MS)) begin
          state_d = DRS_IDLE;
          ev[DRS_IRQ_DONE_BIT] = 1'b1;
        end
      end
      default: state_d = DRS_PU;
    endcase
    // Trip is cleared on entry to the sequence, well inside the alarm deadline.
    if (state_q == DRS_SEQ) begin
      trip_d = 1'b0;
    end else if (fault_event) begin
      trip_d = 1'b1;
      ev[DRS_IRQ_TRIP_BIT] = ~trip_q;
    end
    if (rem_err_d && !rem_err_q) begin
      ev[DRS_IRQ_REMERR_BIT] = 1'b1;
    end
  end

  // The 4 s watch only runs while the terminal has been on since power-up.
  // The power-up sequence gives software time to assign the terminal before an off level ends the watch.
  always_comb begin
    pu_hold_d = pu_hold_q;
    pu_ms_d = pu_ms_q;
    rem_err_d = rem_err_q;
    if (!rst_level) begin
      pu_hold_d = pu_hold_q && (state_q != DRS_IDLE);
    end else if (pu_hold_q && tick && pu_ms_q <= 13'(DRS_PU_HOLD_MS)) begin
      pu_ms_d = pu_ms_q + 13'd1;
    end
    if (pu_hold_q && pu_ms_q > 13'(DRS_PU_HOLD_MS)) begin
      rem_err_d = 1'b1;
    end else if (rem_err_q && !rst_level && operator_key) begin
      rem_err_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_prev_q <= 1'b0;
      on_ms_q <= 8'h00;
      fired_q <= 1'b0;
      state_q <= DRS_PU;
      seq_ms_q <= 8'h00;
      trip_q <= 1'b0;
      pu_hold_q <= 1'b1;
      pu_ms_q <= 13'h0000;
      rem_err_q <= 1'b0;
    end else if (clk_en) begin
      rst_prev_q <= rst_prev_d;
      on_ms_q <= on_ms_d;
      fired_q <= fired_d;
      state_q <= state_d;
      seq_ms_q <= seq_ms_d;
      trip_q <= trip_d;
      pu_hold_q <= pu_hold_d;
      pu_ms_q <= pu_ms_d;
      rem_err_q <= rem_err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs. Run is not gated after the sequence, so the motor restarts at once.
  logic motor_q, motor_d;

  always_comb begin
    motor_d = run_cmd && !trip_q && !rst_level && (state_q == DRS_IDLE);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      motor_q <= 1'b0;
    end else if (clk_en) begin
      motor_q <= motor_d;
    end
  end

  assign motor_enable = motor_q;
  assign alarm_out = trip_q;
  assign powerup_reset = (state_q != DRS_IDLE);
  assign remote_link_error_message = rem_err_q;

endmodule

// ===== testbench/drs_assertions.sv
`timescale 1ns/10ps
module drs_assertions #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [4:0] input_terminal,
  input wire logic fault_event,
  input wire logic run_cmd,
  input wire logic operator_key,
  input wire logic motor_enable,
  input wire logic alarm_out,
  input wire logic powerup_reset,
  input wire logic remote_link_error_message
);
  localparam int SEQ_HI = 3 * TICK_CYCLES + 4;
  localparam int MIN_W = 11 * TICK_CYCLES;
  // The last finished pulse is kept, as trailing mode fires after the pin is off.
  int on_q, on_d, len_q, len_d;
  always_comb begin
    on_d = (input_terminal != 5'h00) ? on_q + 1 : 0;
    len_d = (input_terminal == 5'h00 && on_q != 0) ? on_q : len_q;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      on_q <= 0;
      len_q <= 0;
    end else begin
      on_q <= on_d;
      len_q <= len_d;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence seq_busy;
    powerup_reset [*8];
  endsequence
  a_motor_cause: assert property (
    motor_enable |-> $past(run_cmd) && !$past(powerup_reset)) else $error("Motor on without cause.");
  a_motor_seq_off: assert property (
    powerup_reset |=> !motor_enable) else $error("Motor on during reset.");
  a_trip_latch: assert property (
    clk_en && fault_event && !powerup_reset |=> alarm_out) else $error("Fault did not trip.");
  a_alarm_clear: assert property (
    $rose(powerup_reset) |-> ##[0:2] !alarm_out) else $error("Alarm kept in reset.");
  a_alarm_kept: assert property (
    $fell(alarm_out) |-> powerup_reset || $past(powerup_reset)) else $error("Alarm dropped alone.");
  a_seq_length: assert property (
    $rose(powerup_reset) |-> seq_busy ##[1:SEQ_HI] !powerup_reset) else $error("Bad reset length.");
  a_pulse_width: assert property (
    $rose(powerup_reset) |-> on_q >= MIN_W || len_q >= MIN_W) else $error("Short pulse taken.");
  a_run_restart: assert property (
    $fell(powerup_reset) && run_cmd && !alarm_out && !fault_event && input_terminal == 5'h00
      && $past(input_terminal, 4) == 5'h00
      |-> ##[1:2] motor_enable) else $error("Motor did not restart.");
  a_remote_clear: assert property (
    $fell(remote_link_error_message) |-> $past(operator_key) || $past(operator_key, 2))
    else $error("Link error cleared without key.");
endmodule
bind drs_top drs_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_drs_assertions (.sys_clk(sys_clk), .rst(rst),
  .clk_en(clk_en),
  .input_terminal(input_terminal), .fault_event(fault_event), .run_cmd(run_cmd),
  .operator_key(operator_key), .motor_enable(motor_enable), .alarm_out(alarm_out),
  .powerup_reset(powerup_reset), .remote_link_error_message(remote_link_error_message));

// ===== testbench/drs_switch.sv
`timescale 1ns/10ps
module drs_switch (
  input wire logic sys_clk,
  output logic [4:0] contact
);
  // Open contacts are pulled low, so a released terminal reads off.
  initial contact = 5'h00;
  task automatic press(input int idx);
    contact[idx] <= 1'b1;
  endtask
  task automatic drop(input int idx);
    contact[idx] <= 1'b0;
  endtask
endmodule

// ===== testbench/drs_top_test.sv
`timescale 1ns/10ps
module drs_top_test;
  import drs_pkg::*;
  localparam int TK = 10;
  logic sys_clk, rst, ce, psel, penable, pwrite, fault_event, run_cmd, operator_key, e, saw;
  logic pready, pslverr, motor_enable, alarm_out, powerup_reset, remote_err, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] term;
  int mismatches, total_checks;
  drs_switch i_drs_switch (.sys_clk(sys_clk), .contact(term));
  drs_top #(.TICK_CYCLES(TK)) i_drs_top (.sys_clk(sys_clk), .rst(rst), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .input_terminal(term), .fault_event(fault_event),
    .run_cmd(run_cmd), .operator_key(operator_key), .motor_enable(motor_enable),
    .alarm_out(alarm_out), .powerup_reset(powerup_reset), .remote_link_error_message(remote_err),
    .irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  task automatic fault;
    fault_event <= 1'b1;
    @(posedge sys_clk);
    fault_event <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // The alarm is judged 30 ms after the pin goes on, whatever the edge mode.
  task automatic pulse(input int w, input logic mid_alarm, input logic fires);
    saw = 1'b0;
    i_drs_switch.press(0);
    for (int i = 0; i < 30 * TK; i++) begin
      @(posedge sys_clk);
      saw |= powerup_reset;
      if (i == w - 5) check(alarm_out, mid_alarm);
      if (i == w) i_drs_switch.drop(0);
    end
    check(saw, fires);
    check(alarm_out, !fires);
    repeat (5 * TK) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #3000000;
    mismatches++;
    test_done();
  end
  initial begin
    {rst, psel, penable, pwrite, fault_event, run_cmd, operator_key} = 7'h40;
    paddr = 8'h00;
    pwdata = 32'h0;
    ce = 1'b1;
    mismatches = 0;
    total_checks = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check(powerup_reset, 1'b1);
    repeat (5 * TK) @(posedge sys_clk);
    check(powerup_reset, 1'b0);
    rd_chk(DRS_IRQ_STAT_OFS, 32'h1);
    for (int i = 0; i < 5; i++) rd_chk(8'(i * 4), 32'h0);
    rd_chk(DRS_CTRL_OFS, 32'h0);
    rd_chk(DRS_IRQ_MASK_OFS, 32'h0);
    apb(1'b1, 8'h28, 32'h12);
    check(e, 1'b1);
    apb(1'b1, DRS_IRQ_STAT_OFS, 32'h1);
    apb(1'b1, DRS_ASSIGN1_OFS, 32'h12);
    apb(1'b1, DRS_POL_OFS, 32'h1f);
    rd_chk(DRS_POL_OFS, 32'h1e);
    rd_chk(DRS_IRQ_STAT_OFS, 32'h8);
    apb(1'b1, DRS_IRQ_STAT_OFS, 32'h8);
    apb(1'b1, DRS_IRQ_MASK_OFS, 32'h2);
    run_cmd <= 1'b1;
    fault();
    check({alarm_out, motor_enable, irq}, 3'b101);
    rd_chk(DRS_STATUS_OFS, 32'h5);
    pulse(8 * TK, 1'b1, 1'b0);
    $display("end: trip and short pulse");
    pulse(15 * TK, 1'b0, 1'b1);
    check(motor_enable, 1'b1);
    rd_chk(DRS_IRQ_STAT_OFS, 32'h3);
    apb(1'b1, DRS_IRQ_STAT_OFS, 32'h3);
    check(irq, 1'b0);
    $display("end: leading edge");
    apb(1'b1, DRS_IRQ_MASK_OFS, 32'h0);
    apb(1'b1, DRS_CTRL_OFS, 32'h1);
    fault();
    check({alarm_out, irq}, 2'b10);
    pulse(15 * TK, 1'b1, 1'b1);
    check(motor_enable, 1'b1);
    $display("end: trailing edge");
    ce <= 1'b0;
    fault();
    check({alarm_out, motor_enable}, 2'b01);
    ce <= 1'b1;
    $display("end: clock enable low");
    rst <= 1'b1;
    i_drs_switch.press(0);
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b1, DRS_ASSIGN1_OFS, 32'h12);
    repeat (4100 * TK) @(posedge sys_clk);
    check({remote_err, motor_enable}, 2'b10);
    rd_chk(DRS_STATUS_OFS, 32'ha);
    i_drs_switch.drop(0);
    repeat (10) @(posedge sys_clk);
    check(remote_err, 1'b1);
    operator_key <= 1'b1;
    @(posedge sys_clk);
    operator_key <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check(remote_err, 1'b0);
    $display("end: held at power-up");
    test_done();
  end
endmodule
